// ### src/ssw_supervisor.sv
`default_nettype none
module ssw_supervisor #(
  parameter int unsigned      RESET_TICKS  = ssw_pkg::RESET_TICKS,
  parameter int unsigned      WD_TICKS     = ssw_pkg::WD_TICKS,
  parameter int unsigned      TICK_CYCLES  = ssw_pkg::TICK_CYCLES,
  parameter bit               HAS_DISABLE  = 1'b1,
  parameter ssw_pkg::ssw_rst_style_type RST_STYLE = ssw_pkg::SSW_RST_BOTH
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic supply_low_i,
  input  wire logic manual_reset_n_i,
  input  wire logic powerfail_below_i,
  input  wire logic watchdog_kick_in_i,
  input  wire logic watchdog_kick_float_i,
  output var  logic reset_o,
  output var  logic reset_n_o,
  output var  logic powerfail_warn_n_o,
  output var  logic watchdog_expired_n_o
);
  // ----------------------------------------------------------------------
  // Timebase.
  // ----------------------------------------------------------------------
  ssw_tick_if tb_if ();
  assign tb_if.run = 1'b1;

  ssw_timebase #(
    .DIV (TICK_CYCLES)
  ) u_timebase (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tb       (tb_if.src)
  );

  // ----------------------------------------------------------------------
  // Reset generator.
  // ----------------------------------------------------------------------
  ssw_pkg::ssw_state_type state;
  ssw_pkg::ssw_state_type next_state;
  logic [31:0]            rst_cnt;
  logic [31:0]            next_rst_cnt;
  logic                   rst_cause;
  logic                   rst_active;

  // Manual reset starts a reset like undervoltage but leaves the expiry output high; bounce just extends hold.
  assign rst_cause = supply_low_i || !manual_reset_n_i;

  always_comb
  begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    case (state)
      ssw_pkg::SSW_HOLD:
      begin
        next_rst_cnt = 32'h00000000;
        if (!rst_cause)
        begin
          next_state = ssw_pkg::SSW_DELAY;
        end
      end
      ssw_pkg::SSW_DELAY:
      begin
        if (tb_if.tick)
        begin
          next_rst_cnt = rst_cnt + 32'h00000001;
        end
        if (rst_cause)
        begin
          next_state = ssw_pkg::SSW_HOLD;
          next_rst_cnt = 32'h00000000;
        end
        else if (rst_cnt >= RESET_TICKS)
        begin
          next_state = ssw_pkg::SSW_RUN;
        end
      end
      ssw_pkg::SSW_RUN:
      begin
        if (rst_cause)
        begin
          next_state = ssw_pkg::SSW_HOLD;
        end
      end
      default:
      begin
        next_state = ssw_pkg::SSW_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state <= ssw_pkg::SSW_HOLD;
      rst_cnt <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
    end
  end

  assign rst_active = (state != ssw_pkg::SSW_RUN);

  // ----------------------------------------------------------------------
  // Watchdog.
  // ----------------------------------------------------------------------
  logic        kick_prev;
  logic        kick_edge;
  logic        wd_stopped;
  logic [31:0] wd_cnt;
  logic [31:0] next_wd_cnt;
  logic        wd_timeout;
  logic        next_wd_timeout;

  assign kick_edge = watchdog_kick_in_i != kick_prev;
  // A floating kick pin freezes the count; an expiry already shown stays
  // until a kick edge or a reset ends it.
  assign wd_stopped = HAS_DISABLE && watchdog_kick_float_i;

  always_comb
  begin
    next_wd_cnt = wd_cnt;
    next_wd_timeout = wd_timeout;
    if (rst_active || kick_edge)
    begin
      next_wd_cnt = 32'h00000000;
      next_wd_timeout = 1'b0;
    end
    else if (!wd_stopped && tb_if.tick)
    begin
      if (wd_cnt + 32'h00000001 >= WD_TICKS)
      begin
        next_wd_timeout = 1'b1;
      end
      else
      begin
        next_wd_cnt = wd_cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      kick_prev <= 1'b0;
      wd_cnt <= 32'h00000000;
      wd_timeout <= 1'b0;
    end
    else
    begin
      kick_prev <= watchdog_kick_in_i;
      wd_cnt <= next_wd_cnt;
      wd_timeout <= next_wd_timeout;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers.
  // ----------------------------------------------------------------------
  logic next_reset;
  logic next_reset_n;
  logic next_wdo_n;
  logic next_pfo_n;

  // Which reset pins a variant drives; an unused pin sits at its idle level once resetn_i is high (resetn_i low asserts both).
  function automatic logic style_has_high(input ssw_pkg::ssw_rst_style_type style);
    return style != ssw_pkg::SSW_RST_LOW_ONLY;
  endfunction

  function automatic logic style_has_low(input ssw_pkg::ssw_rst_style_type style);
    return style != ssw_pkg::SSW_RST_HIGH_ONLY;
  endfunction

  always_comb
  begin
    next_reset = 1'b0;
    next_reset_n = 1'b1;
    if (style_has_high(RST_STYLE))
    begin
      next_reset = rst_active;
    end
    if (style_has_low(RST_STYLE))
    begin
      next_reset_n = !rst_active;
    end
    next_wdo_n = !(wd_timeout || supply_low_i);
    next_pfo_n = !powerfail_below_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      reset_o <= 1'b1;
      reset_n_o <= 1'b0;
      watchdog_expired_n_o <= 1'b1;
      powerfail_warn_n_o <= 1'b1;
    end
    else
    begin
      reset_o <= next_reset;
      reset_n_o <= next_reset_n;
      watchdog_expired_n_o <= next_wdo_n;
      powerfail_warn_n_o <= next_pfo_n;
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_mr_starts_reset: assert property (
    !manual_reset_n_i |=> state == ssw_pkg::SSW_HOLD)
    else $error("manual reset did not hold reset");
  chk_pfo_follows: assert property (
    powerfail_below_i |=> !powerfail_warn_n_o)
    else $error("warning not low below reference");
  chk_pfo_high: assert property (
    !powerfail_below_i |=> powerfail_warn_n_o)
    else $error("warning low above reference");
  chk_wd_held_reset: assert property (
    rst_active |=> wd_cnt == 32'h00000000 && !wd_timeout)
    else $error("watchdog counted during reset");
  chk_kick_clears: assert property (
    kick_edge |=> wd_cnt == 32'h00000000)
    else $error("kick edge did not clear watchdog");
  chk_wdo_low_uv: assert property (
    supply_low_i |=> !watchdog_expired_n_o)
    else $error("expiry not low on undervoltage");
  chk_expiry_sticks: assert property (
    wd_timeout && !kick_edge && !rst_active |=> wd_timeout)
    else $error("expiry dropped without kick");
  chk_brownout_restart: assert property (
    state == ssw_pkg::SSW_DELAY && rst_cause |=> state == ssw_pkg::SSW_HOLD && rst_cnt == 0)
    else $error("brownout did not restart delay");
  chk_release_delay: assert property (
    $rose(state == ssw_pkg::SSW_RUN) |-> rst_cnt >= RESET_TICKS)
    else $error("reset released early");
  chk_out_style: assert property (
    RST_STYLE == ssw_pkg::SSW_RST_BOTH |-> reset_o != reset_n_o)
    else $error("reset outputs not complementary");

  chk_reset_asserted: assert property (
    rst_active |=> reset_o == style_has_high(RST_STYLE)
      && reset_n_o == !style_has_low(RST_STYLE))
    else $error("reset outputs not asserted");
  chk_reset_released: assert property (
    !rst_active |=> !reset_o && reset_n_o)
    else $error("reset outputs not released");
  chk_hold_clears: assert property (
    state == ssw_pkg::SSW_HOLD |=> rst_cnt == 32'h00000000)
    else $error("delay timer not cleared while held");
  chk_hold_to_delay: assert property (
    state == ssw_pkg::SSW_HOLD && !rst_cause |=> state == ssw_pkg::SSW_DELAY)
    else $error("delay timer did not start");
  chk_tick_paced: assert property (
    state == ssw_pkg::SSW_DELAY && !rst_cause && !tb_if.tick |=> rst_cnt == $past(rst_cnt))
    else $error("delay timer moved without tick");
  chk_kick_ends_expiry: assert property (
    kick_edge && !rst_active |=> !wd_timeout && wd_cnt == 32'h00000000)
    else $error("kick edge did not end expiry");
  chk_float_freezes: assert property (
    wd_stopped && !rst_active && !kick_edge |=> wd_cnt == $past(wd_cnt))
    else $error("watchdog counted while kick floating");
  chk_wd_period: assert property (
    $rose(wd_timeout) |-> wd_cnt == WD_TICKS - 1)
    else $error("watchdog expired at wrong count");
  chk_wdo_recovers: assert property (
    !supply_low_i && !wd_timeout |=> watchdog_expired_n_o)
    else $error("expiry low without cause");

  // ----------------------------------------------------------------------
  // Cover points.
  // ----------------------------------------------------------------------
  cov_powerup: cover property ($rose(state == ssw_pkg::SSW_RUN));
  cov_timeout: cover property ($rose(wd_timeout));
  cov_brownout: cover property (state == ssw_pkg::SSW_DELAY && rst_cause);
  cov_kick: cover property (!rst_active && kick_edge);
  cov_float: cover property (wd_stopped && !rst_active && tb_if.tick);
endmodule
`default_nettype wire

// ### src/ssw_pkg.sv
`default_nettype none
package ssw_pkg;
  // Clock rate in Hz and the printed timing figures.
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RESET_PULSE_MS = 200;
  localparam int unsigned RESET_PULSE_MIN_MS = 140;
  localparam int unsigned RESET_PULSE_MAX_MS = 280;
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned WD_TIMEOUT_MIN_MS = 1000;
  localparam int unsigned WD_TIMEOUT_MAX_MS = 2250;
  // Timebase tick period in microseconds; counters count ticks.
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned RESET_TICKS = RESET_PULSE_MS * 1000 / TICK_US;
  localparam int unsigned WD_TICKS = WD_TIMEOUT_MS * 1000 / TICK_US;
  // Reset output style.
  typedef enum logic [1:0] {
    SSW_RST_HIGH_ONLY,
    SSW_RST_LOW_ONLY,
    SSW_RST_BOTH
  } ssw_rst_style_type;
  typedef enum logic [1:0] {
    SSW_HOLD,
    SSW_DELAY,
    SSW_RUN
  } ssw_state_type;
endpackage
`default_nettype wire

// ### src/ssw_tick_if.sv
`default_nettype none
interface ssw_tick_if;
  logic tick;
  logic run;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface
`default_nettype wire

// ### src/ssw_timebase.sv
`default_nettype none
module ssw_timebase #(
  parameter int unsigned DIV = ssw_pkg::TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  ssw_tick_if.src   tb
);
  // ----------------------------------------------------------------------
  // Free-running divider producing a one-cycle tick.
  // ----------------------------------------------------------------------
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb
  begin
    next_cnt = cnt + 32'h00000001;
    next_tick = 1'b0;
    if (cnt >= DIV - 1)
    begin
      next_cnt = 32'h00000000;
      next_tick = tb.run;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cnt <= 32'h00000000;
      tb.tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tb.tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ### testbench/ssw_host_model.sv
`default_nettype none
module ssw_host_model #(
  parameter int unsigned PERIOD = 20
) (
  input  wire logic clk_i,
  input  wire logic kick_en_i,
  input  wire logic loop_en_i,
  input  wire logic button_n_i,
  input  wire logic watchdog_expired_n_i,
  output var  logic watchdog_kick_in_o,
  output var  logic manual_reset_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;
  logic        kick_q = 1'b0;
  always @(posedge clk_i)
  begin
    cnt <= (cnt + 1) % PERIOD;
    if (kick_en_i && cnt == 0)
    begin
      kick_q <= #1 ~kick_q;
    end
  end
  assign watchdog_kick_in_o = kick_q;
  // A held button is many cycles wide; expiry may be looped into it.
  assign manual_reset_n_o = button_n_i & (watchdog_expired_n_i | ~loop_en_i);
endmodule
`default_nettype wire

// ### testbench/supply_supervisor_watchdog_reset_tb_top.sv
`default_nettype none
module supply_supervisor_watchdog_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, resetn_i = 1'b0, supply_low_i = 1'b0, powerfail_below_i = 1'b0;
  logic float_i = 1'b0, kick_en = 1'b0, loop_en = 1'b0, button_n = 1'b1, watch = 1'b0;
  logic mr_n, kick, rst, rst_n, pfo_n, wdo_n;
  int   error_cnt = 0, comparisons = 0, cyc = 0, lows = 0;

  ssw_supervisor #(.RESET_TICKS(5), .WD_TICKS(10), .TICK_CYCLES(4)) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .supply_low_i(supply_low_i),
    .manual_reset_n_i(mr_n), .powerfail_below_i(powerfail_below_i),
    .watchdog_kick_in_i(kick), .watchdog_kick_float_i(float_i), .reset_o(rst),
    .reset_n_o(rst_n), .powerfail_warn_n_o(pfo_n), .watchdog_expired_n_o(wdo_n));
  ssw_host_model host_u (.clk_i(clk_i), .kick_en_i(kick_en), .loop_en_i(loop_en),
    .button_n_i(button_n), .watchdog_expired_n_i(wdo_n),
    .watchdog_kick_in_o(kick), .manual_reset_n_o(mr_n));

  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (watch && wdo_n !== 1'b1) lows++;
    if (cyc == 3000)
    begin
      error_cnt++;
      conclude;
    end
  end

  // ----
  // Helpers.
  // ----
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_for(input logic val, input bit on_wdo, output int n);
    n = 0;
    while (((on_wdo ? wdo_n : rst_n) !== val) && n < 200)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic conclude;
    $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // Scenarios.
  // ----
  task automatic t_powerup;
    int n;
    chk(rst, 1'b1);
    chk(rst_n, 1'b0);
    wait_for(1'b1, 0, n);
    chk(n inside {[17:30]}, 1'b1);
    chk(rst, 1'b0);
    $display("powerup done");
  endtask
  task automatic t_watchdog;
    int n;
    wait_for(1'b0, 1, n);
    chk(n inside {[34:50]}, 1'b1);
    step(20);
    chk(wdo_n, 1'b0);
    kick_en = 1'b1;
    wait_for(1'b1, 1, n);
    chk(n <= 24, 1'b1);
    watch = 1'b1;
    step(150);
    chk(lows == 0, 1'b1);
    chk(wdo_n, 1'b1);
    float_i = 1'b1;
    kick_en = 1'b0;
    step(100);
    chk(lows == 0, 1'b1);
    kick_en = 1'b1;
    float_i = 1'b0;
    watch = 1'b0;
    $display("watchdog done");
  endtask
  task automatic t_manual;
    int n;
    button_n = 1'b0;
    step(3);
    chk(rst, 1'b1);
    powerfail_below_i = 1'b1;
    step(2);
    chk(pfo_n, 1'b0);
    chk(wdo_n, 1'b1);
    powerfail_below_i = 1'b0;
    step(2);
    chk(pfo_n, 1'b1);
    repeat (3)
    begin
      button_n = 1'b1;
      step(2);
      button_n = 1'b0;
      step(2);
      chk(rst_n, 1'b0);
    end
    button_n = 1'b1;
    wait_for(1'b1, 0, n);
    chk(n inside {[17:30]}, 1'b1);
    $display("manual done");
  endtask
  task automatic t_brownout;
    int n;
    supply_low_i = 1'b1;
    step(2);
    chk(wdo_n, 1'b0);
    supply_low_i = 1'b0;
    step(2);
    chk(wdo_n, 1'b1);
    chk(rst_n, 1'b0);
    step(8);
    supply_low_i = 1'b1;
    step(2);
    supply_low_i = 1'b0;
    wait_for(1'b1, 0, n);
    chk(n inside {[17:30]}, 1'b1);
    powerfail_below_i = 1'b1;
    step(3);
    chk(pfo_n, 1'b0);
    chk(rst_n, 1'b1);
    chk(wdo_n, 1'b1);
    powerfail_below_i = 1'b0;
    step(2);
    chk(pfo_n, 1'b1);
    $display("brownout done");
  endtask
  task automatic t_loop;
    int n;
    kick_en = 1'b0;
    loop_en = 1'b1;
    wait_for(1'b0, 0, n);
    chk(n inside {[14:60]}, 1'b1);
    wait_for(1'b1, 1, n);
    chk(n <= 4, 1'b1);
    kick_en = 1'b1;
    wait_for(1'b1, 0, n);
    chk(n inside {[15:30]}, 1'b1);
    loop_en = 1'b0;
    $display("loop done");
  endtask

  initial
  begin
    step(5);
    resetn_i = 1'b1;
    t_powerup;
    t_watchdog;
    t_manual;
    t_brownout;
    t_loop;
    conclude;
  end
endmodule
`default_nettype wire
